/* File: sram_tap_pkg.sv */
`default_nettype none

package sram_tap_pkg;

    // Scan register lengths
    localparam int IR_WIDTH = 3;
    localparam int ID_WIDTH = 32;
    localparam int BSR_WIDTH = 75;
    localparam int PIN_SYNC_WIDTH = 3;

    // Instruction codes
    localparam logic [2:0] OP_EXTEST = 3'h0;
    localparam logic [2:0] OP_IDCODE = 3'h1;
    localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
    localparam logic [2:0] OP_SAMPLE_PRELOAD = 3'h4;
    localparam logic [2:0] OP_BYPASS = 3'h7;

    // Value loaded into the instruction shifter at Capture-IR
    localparam logic [2:0] IR_CAPTURE_VALUE = 3'h1;
    // Instruction selected after reset and in Test-Logic-Reset
    localparam logic [2:0] IR_RESET_VALUE = OP_IDCODE;

    // Identification field positions
    localparam int ID_REV_MSB = 31;
    localparam int ID_REV_LSB = 28;
    localparam int ID_DEPTH_MSB = 27;
    localparam int ID_DEPTH_LSB = 23;
    localparam int ID_WIDTH_MSB = 22;
    localparam int ID_WIDTH_LSB = 18;
    localparam int ID_DEV_MSB = 17;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_MFR_MSB = 11;
    localparam int ID_MFR_LSB = 1;
    localparam int ID_PRESENT_BIT = 0;

    // Identification field values
    localparam logic [3:0] ID_REVISION = 4'h0;
    localparam logic [4:0] DEPTH_ONE_MEG = 5'h07;
    localparam logic [4:0] DEPTH_HALF_MEG = 5'h06;
    localparam logic [4:0] WIDTH_X18 = 5'h03;
    localparam logic [4:0] WIDTH_X32_X36 = 5'h04;
    localparam logic ID_PRESENT = 1'h1;

    // Test clock limit and its least period in system clocks
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int TCK_MIN_PERIOD_NS = 100;
    localparam int TCK_MIN_CYCLES = (TCK_MIN_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    // Serial test pins as one bundle
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

    // Boundary ring, cell 75 in the top bit, cell 1 in bit 0
    typedef struct packed {
        logic address_bit_zero;   // Cell 75
        logic address_bit_one;    // Cell 74
        logic [33:0] cells_73_40; // Cells 73 down to 40
        logic sram_clk;           // Cell 39
        logic [26:0] cells_38_12; // Cells 38 down to 12
        logic sleep_input;        // Cell 11
        logic [8:0] cells_10_2;   // Cells 10 down to 2
        logic burst_order_select; // Cell 1
    } ring_t;

    // TAP controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_t;

    // Data register chosen by the current instruction
    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_ID, SEL_BOUNDARY
    } dr_sel_t;

endpackage

`default_nettype wire

/* File: pin_sync.sv */
`default_nettype none

// Two-stage synchroniser for levels from outside the clock domain
module pin_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q; // First stage, read only by the second
    logic [W-1:0] sync_q; // Second stage, safe to use

    // Both stages clear on reset so nothing unknown escapes
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

/* File: scan_reg.sv */
`default_nettype none

// Capture-and-shift register, shifts towards bit 0
module scan_reg #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic [W-1:0] capture_val,
    input wire logic serial_in,
    output logic [W-1:0] value_q
);

    // Capture has priority; the controller never asks for both at once
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            value_q <= '0;
        end
        else if (capture_en)
        begin
            value_q <= capture_val;
        end
        else if (shift_en)
        begin
            // New bit enters at the top, bit 0 leaves first
            value_q <= {serial_in, value_q[W-1:1]};
        end
    end

endmodule

`default_nettype wire

/* File: sram_tap.sv */
`default_nettype none

// Behaviour
// - Instruction 3, bypass 1, ID 32, boundary 75
// - ID bits 31:28 revision, all zeros
// - ID bits 27:23 depth 00111 or 00110
// - ID bits 22:18 width 00011 or 00100
// - ID bits 11:1 maker, 17:12 device field
// - ID bit 0 always one
// - EXTEST captures ring, boundary path, outputs off
// - IDCODE loads ID onto path, memory untouched
// - SAMPLE Z captures ring, outputs high impedance
// - BYPASS puts one-bit register on path
// - Chain cells 1, 11, 39, 74, 75 fixed
// - Update-DR under sample/preload does nothing
module sram_tap #(
    parameter bit ONE_MEG_X18 = 1'b1,           // 1 = 1M x18, 0 = 512K x32/x36
    parameter logic [10:0] MFR_CODE = 11'h155,  // Arbitrary value
    parameter logic [5:0] DEVICE_CODE = 6'h00   // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire sram_tap_pkg::ring_t ring_in,
    output logic tdo,
    output logic tdo_oe_n,
    output logic sram_out_disable
);

    // Fixed identification word for this organisation
    function automatic logic [31:0] id_word();
        logic [31:0] w;
        w = '0;
        w[sram_tap_pkg::ID_REV_MSB:sram_tap_pkg::ID_REV_LSB] = sram_tap_pkg::ID_REVISION;
        w[sram_tap_pkg::ID_DEPTH_MSB:sram_tap_pkg::ID_DEPTH_LSB] =
            ONE_MEG_X18 ? sram_tap_pkg::DEPTH_ONE_MEG : sram_tap_pkg::DEPTH_HALF_MEG;
        w[sram_tap_pkg::ID_WIDTH_MSB:sram_tap_pkg::ID_WIDTH_LSB] =
            ONE_MEG_X18 ? sram_tap_pkg::WIDTH_X18 : sram_tap_pkg::WIDTH_X32_X36;
        w[sram_tap_pkg::ID_DEV_MSB:sram_tap_pkg::ID_DEV_LSB] = DEVICE_CODE;
        w[sram_tap_pkg::ID_MFR_MSB:sram_tap_pkg::ID_MFR_LSB] = MFR_CODE;
        w[sram_tap_pkg::ID_PRESENT_BIT] = sram_tap_pkg::ID_PRESENT;
        return w;
    endfunction

    // Which data register an instruction puts between TDI and TDO
    function automatic sram_tap_pkg::dr_sel_t dr_select(input logic [2:0] op);
        sram_tap_pkg::dr_sel_t s;
        s = sram_tap_pkg::SEL_BYPASS;
        unique case (op)
            sram_tap_pkg::OP_EXTEST,
            sram_tap_pkg::OP_SAMPLE_Z,
            sram_tap_pkg::OP_SAMPLE_PRELOAD: s = sram_tap_pkg::SEL_BOUNDARY;
            sram_tap_pkg::OP_IDCODE: s = sram_tap_pkg::SEL_ID;
            // Reserved codes fall back to bypass as the safest path
            default: s = sram_tap_pkg::SEL_BYPASS;
        endcase
        return s;
    endfunction

    sram_tap_pkg::tap_pins_t pins_s; // Synchronised test pins
    logic [sram_tap_pkg::BSR_WIDTH-1:0] ring_sync; // Synchronised ring, flat
    sram_tap_pkg::ring_t ring_s; // Synchronised ring, by field
    logic tck_d_q; // Previous synchronised test clock
    logic tck_rise; // One-cycle pulse on a test clock rising edge
    logic tck_fall; // One-cycle pulse on a test clock falling edge
    sram_tap_pkg::tap_state_t state_q; // TAP controller state
    logic [2:0] ir_q; // Active instruction
    logic [2:0] ir_shift_q; // Instruction shifter
    logic bypass_q; // Single bypass cell
    logic [31:0] id_q; // Identification shifter
    logic [sram_tap_pkg::BSR_WIDTH-1:0] bsr_q; // Boundary shifter
    sram_tap_pkg::dr_sel_t sel; // Data register on the path now
    logic tdo_q;
    logic tdo_oe_n_q;
    logic out_disable_q;

    // The test clock is just another slow pin: sampled, never used as a clock
    pin_sync #(
        .W(sram_tap_pkg::PIN_SYNC_WIDTH)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({tck, tms, tdi}),
        .sync_out(pins_s)
    );

    // Ring pins move with the memory clock; two stages keep capture clean
    pin_sync #(
        .W(sram_tap_pkg::BSR_WIDTH)
    ) u_ring_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(ring_in),
        .sync_out(ring_sync)
    );

    assign ring_s = sram_tap_pkg::ring_t'(ring_sync);
    assign sel = dr_select(ir_q);

    // Edge finder on the synchronised test clock
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tck_d_q <= 1'b0;
        end
        else
        begin
            tck_d_q <= pins_s.tck;
        end
    end

    assign tck_rise = pins_s.tck & ~tck_d_q;
    assign tck_fall = ~pins_s.tck & tck_d_q;

    // TAP controller, stepped on each test clock rising edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= sram_tap_pkg::TEST_LOGIC_RESET;
        end
        else if (tck_rise)
        begin
            unique case (state_q)
                sram_tap_pkg::TEST_LOGIC_RESET:
                    state_q <= pins_s.tms ? sram_tap_pkg::TEST_LOGIC_RESET : sram_tap_pkg::RUN_TEST_IDLE;
                sram_tap_pkg::RUN_TEST_IDLE:
                    state_q <= pins_s.tms ? sram_tap_pkg::SELECT_DR : sram_tap_pkg::RUN_TEST_IDLE;
                sram_tap_pkg::SELECT_DR:
                    state_q <= pins_s.tms ? sram_tap_pkg::SELECT_IR : sram_tap_pkg::CAPTURE_DR;
                sram_tap_pkg::CAPTURE_DR:
                    state_q <= pins_s.tms ? sram_tap_pkg::EXIT1_DR : sram_tap_pkg::SHIFT_DR;
                sram_tap_pkg::SHIFT_DR:
                    state_q <= pins_s.tms ? sram_tap_pkg::EXIT1_DR : sram_tap_pkg::SHIFT_DR;
                sram_tap_pkg::EXIT1_DR:
                    state_q <= pins_s.tms ? sram_tap_pkg::UPDATE_DR : sram_tap_pkg::PAUSE_DR;
                sram_tap_pkg::PAUSE_DR:
                    state_q <= pins_s.tms ? sram_tap_pkg::EXIT2_DR : sram_tap_pkg::PAUSE_DR;
                sram_tap_pkg::EXIT2_DR:
                    state_q <= pins_s.tms ? sram_tap_pkg::UPDATE_DR : sram_tap_pkg::SHIFT_DR;
                sram_tap_pkg::UPDATE_DR:
                    state_q <= pins_s.tms ? sram_tap_pkg::SELECT_DR : sram_tap_pkg::RUN_TEST_IDLE;
                sram_tap_pkg::SELECT_IR:
                    state_q <= pins_s.tms ? sram_tap_pkg::TEST_LOGIC_RESET : sram_tap_pkg::CAPTURE_IR;
                sram_tap_pkg::CAPTURE_IR:
                    state_q <= pins_s.tms ? sram_tap_pkg::EXIT1_IR : sram_tap_pkg::SHIFT_IR;
                sram_tap_pkg::SHIFT_IR:
                    state_q <= pins_s.tms ? sram_tap_pkg::EXIT1_IR : sram_tap_pkg::SHIFT_IR;
                sram_tap_pkg::EXIT1_IR:
                    state_q <= pins_s.tms ? sram_tap_pkg::UPDATE_IR : sram_tap_pkg::PAUSE_IR;
                sram_tap_pkg::PAUSE_IR:
                    state_q <= pins_s.tms ? sram_tap_pkg::EXIT2_IR : sram_tap_pkg::PAUSE_IR;
                sram_tap_pkg::EXIT2_IR:
                    state_q <= pins_s.tms ? sram_tap_pkg::UPDATE_IR : sram_tap_pkg::SHIFT_IR;
                sram_tap_pkg::UPDATE_IR:
                    state_q <= pins_s.tms ? sram_tap_pkg::SELECT_DR : sram_tap_pkg::RUN_TEST_IDLE;
            endcase
        end
    end

    // Instruction shifter: fixed pattern on capture, LSB out first
    scan_reg #(
        .W(sram_tap_pkg::IR_WIDTH)
    ) u_ir_shift (
        .sys_clk(sys_clk),
        .rst(rst),
        .capture_en(tck_rise && state_q == sram_tap_pkg::CAPTURE_IR),
        .shift_en(tck_rise && state_q == sram_tap_pkg::SHIFT_IR),
        .capture_val(sram_tap_pkg::IR_CAPTURE_VALUE),
        .serial_in(pins_s.tdi),
        .value_q(ir_shift_q)
    );

    // Active instruction: takes the shifter at Update-IR, IDCODE in reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ir_q <= sram_tap_pkg::IR_RESET_VALUE;
        end
        else if (tck_rise && state_q == sram_tap_pkg::TEST_LOGIC_RESET)
        begin
            ir_q <= sram_tap_pkg::IR_RESET_VALUE;
        end
        else if (tck_rise && state_q == sram_tap_pkg::UPDATE_IR)
        begin
            // Reserved codes are stored but only ever select bypass
            ir_q <= ir_shift_q;
        end
    end

    // Identification shifter, loaded at Capture-DR under IDCODE
    scan_reg #(
        .W(sram_tap_pkg::ID_WIDTH)
    ) u_id_shift (
        .sys_clk(sys_clk),
        .rst(rst),
        .capture_en(tck_rise && state_q == sram_tap_pkg::CAPTURE_DR && sel == sram_tap_pkg::SEL_ID),
        .shift_en(tck_rise && state_q == sram_tap_pkg::SHIFT_DR && sel == sram_tap_pkg::SEL_ID),
        .capture_val(id_word()),
        .serial_in(pins_s.tdi),
        .value_q(id_q)
    );

    // Boundary shifter, cell 1 sits next to TDO; there is no update latch,
    // so Update-DR leaves it and the outputs alone, as Pause-DR would
    scan_reg #(
        .W(sram_tap_pkg::BSR_WIDTH)
    ) u_bsr_shift (
        .sys_clk(sys_clk),
        .rst(rst),
        .capture_en(tck_rise && state_q == sram_tap_pkg::CAPTURE_DR && sel == sram_tap_pkg::SEL_BOUNDARY),
        .shift_en(tck_rise && state_q == sram_tap_pkg::SHIFT_DR && sel == sram_tap_pkg::SEL_BOUNDARY),
        .capture_val(ring_s),
        .serial_in(pins_s.tdi),
        .value_q(bsr_q)
    );

    // Bypass cell: clears on capture, then passes TDI with one stage delay
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bypass_q <= 1'b0;
        end
        else if (tck_rise && sel == sram_tap_pkg::SEL_BYPASS)
        begin
            if (state_q == sram_tap_pkg::CAPTURE_DR)
            begin
                bypass_q <= 1'b0;
            end
            else if (state_q == sram_tap_pkg::SHIFT_DR)
            begin
                bypass_q <= pins_s.tdi;
            end
        end
    end

    // TDO changes on the falling edge, driven only in the shift states
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tdo_q <= 1'b0;
            tdo_oe_n_q <= 1'b1;
        end
        else if (tck_fall)
        begin
            if (state_q == sram_tap_pkg::SHIFT_IR)
            begin
                tdo_q <= ir_shift_q[0];
                tdo_oe_n_q <= 1'b0;
            end
            else if (state_q == sram_tap_pkg::SHIFT_DR)
            begin
                unique case (sel)
                    sram_tap_pkg::SEL_ID: tdo_q <= id_q[0];
                    sram_tap_pkg::SEL_BOUNDARY: tdo_q <= bsr_q[0];
                    sram_tap_pkg::SEL_BYPASS: tdo_q <= bypass_q;
                endcase
                tdo_oe_n_q <= 1'b0;
            end
            else
            begin
                tdo_oe_n_q <= 1'b1;
            end
        end
    end

    // Memory outputs are forced off only by EXTEST and SAMPLE Z
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            out_disable_q <= 1'b0;
        end
        else
        begin
            out_disable_q <= (ir_q == sram_tap_pkg::OP_EXTEST) || (ir_q == sram_tap_pkg::OP_SAMPLE_Z);
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe_n = tdo_oe_n_q;
    assign sram_out_disable = out_disable_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Capture-DR step under a given data register
    sequence seq_capture(sram_tap_pkg::dr_sel_t s);
        tck_rise && state_q == sram_tap_pkg::CAPTURE_DR && sel == s;
    endsequence

    // Update-IR step loading a given code
    sequence seq_load_ir(logic [2:0] op);
        tck_rise && state_q == sram_tap_pkg::UPDATE_IR && ir_shift_q == op;
    endsequence

    a_ir_update: assert property (tck_rise && state_q == sram_tap_pkg::UPDATE_IR |=> ir_q == $past(ir_shift_q))
        else $error("instruction not taken at update");
    a_id_revision: assert property (seq_capture(sram_tap_pkg::SEL_ID) |=> id_q[31:28] == 4'h0)
        else $error("revision field wrong");
    a_id_depth: assert property (seq_capture(sram_tap_pkg::SEL_ID)
        |=> id_q[27:23] == (ONE_MEG_X18 ? 5'h07 : 5'h06)) else $error("depth field wrong");
    a_id_width: assert property (seq_capture(sram_tap_pkg::SEL_ID)
        |=> id_q[22:18] == (ONE_MEG_X18 ? 5'h03 : 5'h04)) else $error("width field wrong");
    a_id_maker: assert property (seq_capture(sram_tap_pkg::SEL_ID) |=> id_q[11:1] == MFR_CODE)
        else $error("maker field wrong");
    a_id_present: assert property (seq_capture(sram_tap_pkg::SEL_ID) |=> id_q[0])
        else $error("presence bit not one");
    a_extest_hiz: assert property (seq_load_ir(3'h0) |=> ##1 out_disable_q)
        else $error("outputs not off under extest");
    a_idcode_quiet: assert property (seq_load_ir(3'h1) |=> ##1 !out_disable_q)
        else $error("idcode disturbed memory outputs");
    a_samplez_hiz: assert property (seq_load_ir(3'h2) |=> ##1 out_disable_q)
        else $error("outputs not off under sample z");
    a_preload_sample: assert property (seq_capture(sram_tap_pkg::SEL_BOUNDARY) ##0 (ir_q == 3'h4)
        |=> bsr_q == $past(ring_sync) && !out_disable_q)
        else $error("sample capture wrong");
    a_bypass_path: assert property (tck_rise && state_q == sram_tap_pkg::SHIFT_DR && ir_q == 3'h7
        |=> bypass_q == $past(pins_s.tdi))
        else $error("bypass cell missed tdi");
    a_chain_order: assert property (seq_capture(sram_tap_pkg::SEL_BOUNDARY)
        |=> bsr_q[0] == $past(ring_s.burst_order_select) && bsr_q[10] == $past(ring_s.sleep_input)
        && bsr_q[38] == $past(ring_s.sram_clk) && bsr_q[73] == $past(ring_s.address_bit_one)
        && bsr_q[74] == $past(ring_s.address_bit_zero))
        else $error("boundary cell order wrong");
    a_update_noop: assert property (tck_rise && state_q == sram_tap_pkg::UPDATE_DR && ir_q == 3'h4
        |=> $stable(bsr_q) && $stable(out_disable_q))
        else $error("update changed state under sample");
    a_lsb_first: assert property (tck_rise && state_q == sram_tap_pkg::SHIFT_DR
        && sel == sram_tap_pkg::SEL_BOUNDARY |=> bsr_q[74] == $past(pins_s.tdi) && bsr_q[0] == $past(bsr_q[1]))
        else $error("boundary shift order wrong");

endmodule

`default_nettype wire

/* File: tap_ctrl_model.sv */
`default_nettype none

// Board test controller: drives the serial test link, samples the data-out pin
module tap_ctrl_model (
    input wire logic sys_clk,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    output logic tck,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 100ps;

    // Half period of 4 system clocks: 160 ns period, inside the 10 MHz limit
    localparam int HALF_CLKS = 4;

    // Test clock rests low between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock; data-out is taken late in the high phase, long after it settled.
    // A released data-out has no pull here, so it reads as the inverse of its last level
    task automatic step(input logic m, input logic d, output logic [1:0] q);
        tms = m;
        tdi = d;
        repeat (HALF_CLKS) @(posedge sys_clk);
        #1 tck = 1'b1;
        repeat (HALF_CLKS) @(posedge sys_clk);
        #1 q = {tdo_oe_n, tdo_oe_n ? ~tdo : tdo};
        tck = 1'b0;
    endtask

    // Full scan from Run-Test/Idle back to it; data-in toggles outside shifting
    task automatic scan(input logic ir, input int n, input logic [159:0] din,
                        output logic [159:0] dout, output logic oe_seen);
        logic [1:0] q;
        dout = '0;
        oe_seen = 1'b0;
        step(1'b1, ~tdi, q);
        if (ir)
            step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        // Shifting, last bit leaves with mode select high
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q[0];
            oe_seen = oe_seen | q[1];
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask

    // Five clocks with mode select high, then back to Run-Test/Idle
    task automatic tms_reset();
        logic [1:0] q;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule

`default_nettype wire

/* File: sram_tap_test.sv */
`default_nettype none

module sram_tap_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [10:0] MFR = 11'h2A5; // Arbitrary value
    localparam logic [5:0] DEV = 6'h15; // Arbitrary value

    logic sys_clk;
    logic rst;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    logic sram_out_disable;
    sram_tap_pkg::ring_t ring_in; // I/O ring levels seen by the capture
    int err_total;
    int checks;
    logic [159:0] got; // Bits shifted out, first in bit 0
    logic oe_seen; // Any sample taken while shifting with data-out not driven
    logic [1:0] q;
    logic [31:0] id_exp;
    logic [2:0] ops [3];
    // Data-in pattern, irregular so a shifted or short path shows
    localparam logic [159:0] PAT = {5{32'hC3A5_96E1}};

    sram_tap #(.ONE_MEG_X18(1'b1), .MFR_CODE(MFR), .DEVICE_CODE(DEV)) uut (
        .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .ring_in(ring_in),
        .tdo(tdo), .tdo_oe_n(tdo_oe_n), .sram_out_disable(sram_out_disable));

    tap_ctrl_model ctl (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms), .tdi(tdi));

    // 50 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk_word(input logic [159:0] g, input logic [159:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic chk_flag(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Guard against a hung run
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        err_total = 0;
        checks = 0;
        rst = 1'b1;
        ring_in = '0;
        ops = '{sram_tap_pkg::OP_EXTEST, sram_tap_pkg::OP_SAMPLE_PRELOAD, sram_tap_pkg::OP_SAMPLE_Z};
        id_exp = {sram_tap_pkg::ID_REVISION, sram_tap_pkg::DEPTH_ONE_MEG, sram_tap_pkg::WIDTH_X18,
                  DEV, MFR, sram_tap_pkg::ID_PRESENT};
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_flag(tdo_oe_n, 1'b1);
        chk_flag(sram_out_disable, 1'b0);
        ctl.step(1'b0, 1'b0, q);
        // Identification after reset; 64 bits prove a 32-bit path
        ctl.scan(1'b0, 64, PAT, got, oe_seen);
        chk_word(160'(got[31:0]), 160'(id_exp));
        chk_word(160'(got[63:32]), 160'(PAT[31:0]));
        chk_flag(oe_seen, 1'b0);
        chk_flag(tdo_oe_n, 1'b1);
        // Instruction capture pattern, then the one-bit bypass path
        ctl.scan(1'b1, 3, 160'(sram_tap_pkg::OP_BYPASS), got, oe_seen);
        chk_word(160'(got[2:0]), 160'(sram_tap_pkg::IR_CAPTURE_VALUE));
        ctl.scan(1'b0, 16, PAT, got, oe_seen);
        chk_word(160'(got[15:0]), 160'({PAT[14:0], 1'b0}));
        chk_flag(sram_out_disable, 1'b0);
        // Boundary instructions: ring capture, 75-cell path, output disable
        for (int i = 0; i < 3; i++)
        begin
            ring_in = 75'h5A3_C3A5_0F1E_2D3C_4B69 ^ 75'(i * 32'h0123_4567);
            ctl.scan(1'b1, 3, 160'(ops[i]), got, oe_seen);
            chk_flag(sram_out_disable, ops[i] != sram_tap_pkg::OP_SAMPLE_PRELOAD);
            ctl.scan(1'b0, 83, PAT, got, oe_seen);
            chk_word(160'(got[74:0]), 160'(ring_in));
            chk_word(160'(got[82:75]), 160'(PAT[7:0]));
            chk_flag(sram_out_disable, ops[i] != sram_tap_pkg::OP_SAMPLE_PRELOAD);
        end
        // Mode-select reset brings back identification and live outputs
        ctl.tms_reset();
        chk_flag(sram_out_disable, 1'b0);
        ctl.scan(1'b0, 32, PAT, got, oe_seen);
        chk_word(160'(got[31:0]), 160'(id_exp));
        // Identification chosen by shifting its code, after outputs were forced off
        ctl.scan(1'b1, 3, 160'(sram_tap_pkg::OP_EXTEST), got, oe_seen);
        chk_flag(sram_out_disable, 1'b1);
        ctl.scan(1'b1, 3, 160'(sram_tap_pkg::OP_IDCODE), got, oe_seen);
        chk_flag(sram_out_disable, 1'b0);
        ctl.scan(1'b0, 32, PAT, got, oe_seen);
        chk_word(160'(got[31:0]), 160'(id_exp));
        print_verdict();
    end
endmodule

`default_nettype wire
